// >>> design/psf_pkg.sv
// Package for the program status flag block: address, fields, types
package psf_pkg;
   // ----------------------------------------------------------------
   // Register address and field positions
   // ----------------------------------------------------------------
   localparam logic [7:0] PSF_STATUS_WORD_ADDR = 8'hD0;
   localparam logic [7:0] PSF_STATUS_WORD_RST  = 8'h00;
   localparam int         PSF_CARRY_BIT        = 7;
   localparam int         PSF_AUX_BIT          = 6;
   localparam int         PSF_USER0_BIT        = 5;
   localparam int         PSF_BANK_HI          = 4;
   localparam int         PSF_BANK_LO          = 3;
   localparam int         PSF_OVF_BIT          = 2;
   localparam int         PSF_USER1_BIT        = 1;
   localparam int         PSF_PAR_BIT          = 0;
   localparam logic [2:0] PSF_BIT_NUM_USER0    = 3'h5;
   localparam logic [2:0] PSF_BIT_NUM_USER1    = 3'h1;
   localparam logic [2:0] PSF_BIT_NUM_PAR      = 3'h0;
   localparam logic [7:0] PSF_NIBBLE_MASK      = 8'h0F;
   localparam logic [7:0] PSF_BYTE_ZERO        = 8'h00;
   localparam logic [2:0] PSF_BANK_SHIFT       = 3'h3;

   // ----------------------------------------------------------------
   // Datapath operation codes (one-hot)
   // ----------------------------------------------------------------
   typedef enum logic [6:0] {
      PSF_OP_NONE = 7'h01,
      PSF_OP_ADD  = 7'h02,
      PSF_OP_ADDC = 7'h04,
      PSF_OP_SUBB = 7'h08,
      PSF_OP_MUL  = 7'h10,
      PSF_OP_DIV  = 7'h20,
      PSF_OP_CARRY_ONLY = 7'h40
   } psf_op_t;

   // Operation request from the execution datapath
   typedef struct packed {
      logic    valid;
      psf_op_t op;
      logic [7:0] a;
      logic [7:0] b;
      logic       carry_out;
   } psf_alu_req_t;

   // Software register access, byte or single bit
   typedef struct packed {
      logic       wr;
      logic       bit_wr;
      logic [7:0] addr;
      logic [2:0] bit_num;
      logic [7:0] wdata;
   } psf_sw_req_t;
endpackage : psf_pkg

// >>> design/psf_status_word.sv
// Program status word flag logic of an 8-bit processor core
`timescale 1ns/10ps
module psf_status_word
   import psf_pkg::*;
(
   input  wire logic         clk,
   input  wire logic         rstn,
   input  wire psf_alu_req_t alu_req,
   input  wire psf_sw_req_t  sw_req,
   input  wire logic [7:0]   accumulator,
   input  wire logic [2:0]   reg_index,
   output logic [7:0]        status_word,
   output logic [7:0]        reg_file_addr,
   output logic [1:0]        register_bank_select
);

   // All checks below run on the core clock and rest during reset
   default clocking psf_cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   // ----------------------------------------------------------------
   // Flag state
   // ----------------------------------------------------------------
   logic       carry_flag;
   logic       aux_carry_flag;
   logic       user_flag_zero;
   logic       user_flag_one;
   logic       overflow_flag;
   logic       parity_flag;
   logic       next_aux;
   logic       next_ov;
   logic       next_cy;
   logic       arith;
   logic       sw_hit;
   logic [7:0] next_word;
   logic [15:0] product;

   // Decoding shared by the byte and bit write paths
   function automatic logic bit_written(input psf_sw_req_t r,
                                        input logic [2:0] n,
                                        input logic [7:0] cur);
      logic v;
      v = cur[n];
      if (r.bit_wr)
      begin
         if (r.bit_num == n)
            v = r.wdata[0];
      end
      else
         v = r.wdata[n];
      return v;
   endfunction

   // ----------------------------------------------------------------
   // Arithmetic flag results
   // ----------------------------------------------------------------
   logic [4:0] nib_add;
   logic [4:0] nib_sub;
   logic [7:0] sum8;
   logic [7:0] dif8;
   logic       cin;
   always_comb
   begin
      cin     = (alu_req.op == PSF_OP_ADD) ? 1'b0 : carry_flag;
      nib_add = {1'b0, alu_req.a[3:0]} + {1'b0, alu_req.b[3:0]}
                + {4'h0, cin};
      nib_sub = {1'b0, alu_req.a[3:0]} - {1'b0, alu_req.b[3:0]}
                - {4'h0, carry_flag};
      sum8    = alu_req.a + alu_req.b + {7'h00, cin};
      dif8    = alu_req.a - alu_req.b - {7'h00, carry_flag};
      product = {8'h00, alu_req.a} * {8'h00, alu_req.b};
      arith   = alu_req.valid && (alu_req.op != PSF_OP_NONE);
      next_aux = aux_carry_flag;
      next_ov  = overflow_flag;
      next_cy  = carry_flag;
      case (alu_req.op)
         PSF_OP_ADD, PSF_OP_ADDC:
         begin
            next_aux = nib_add[4];
            next_ov  = (alu_req.a[7] == alu_req.b[7]) &&
                       (sum8[7] != alu_req.a[7]);
            next_cy  = alu_req.carry_out;
         end
         PSF_OP_SUBB:
         begin
            next_aux = nib_sub[4];
            next_ov  = (alu_req.a[7] != alu_req.b[7]) &&
                       (dif8[7] != alu_req.a[7]);
            next_cy  = alu_req.carry_out;
         end
         // Product and quotient carry nothing out, so both carries drop
         PSF_OP_MUL:
         begin
            next_aux = 1'h0;
            next_ov  = (product[15:8] != PSF_BYTE_ZERO);
            next_cy  = 1'h0;
         end
         PSF_OP_DIV:
         begin
            next_aux = 1'h0;
            next_ov  = (alu_req.b == PSF_BYTE_ZERO);
            next_cy  = 1'h0;
         end
         PSF_OP_CARRY_ONLY:
            next_cy = alu_req.carry_out;
         default:
            next_aux = aux_carry_flag;
      endcase
   end

   // Software access decode, byte or bit form
   assign sw_hit = sw_req.wr && (sw_req.addr == PSF_STATUS_WORD_ADDR);
   assign next_word = {carry_flag, aux_carry_flag, user_flag_zero,
                       register_bank_select, overflow_flag,
                       user_flag_one, parity_flag};

   // ----------------------------------------------------------------
   // Hardware-updated flags; datapath wins over a software write
   // ----------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         carry_flag     <= PSF_STATUS_WORD_RST[PSF_CARRY_BIT];
         aux_carry_flag <= PSF_STATUS_WORD_RST[PSF_AUX_BIT];
         overflow_flag  <= PSF_STATUS_WORD_RST[PSF_OVF_BIT];
      end
      else if (arith)
      begin
         carry_flag     <= next_cy;
         aux_carry_flag <= next_aux;
         overflow_flag  <= next_ov;
      end
      else if (sw_hit)
      begin
         carry_flag     <=
            bit_written(sw_req, 3'(PSF_CARRY_BIT), next_word);
         aux_carry_flag <=
            bit_written(sw_req, 3'(PSF_AUX_BIT), next_word);
         overflow_flag  <=
            bit_written(sw_req, 3'(PSF_OVF_BIT), next_word);
      end
   end

   // User flags and bank select: software only, hardware never touches
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         user_flag_zero       <= PSF_STATUS_WORD_RST[PSF_USER0_BIT];
         user_flag_one        <= PSF_STATUS_WORD_RST[PSF_USER1_BIT];
         register_bank_select <= PSF_STATUS_WORD_RST[PSF_BANK_HI:PSF_BANK_LO];
      end
      else if (sw_hit)
      begin
         user_flag_zero <=
            bit_written(sw_req, PSF_BIT_NUM_USER0, next_word);
         user_flag_one  <=
            bit_written(sw_req, PSF_BIT_NUM_USER1, next_word);
         register_bank_select <=
            {bit_written(sw_req, 3'(PSF_BANK_HI), next_word),
             bit_written(sw_req, 3'(PSF_BANK_LO), next_word)};
      end
   end

   // Parity registered so the output is a flop; the status_word bit lags accumulator two cycles
   always_ff @(posedge clk)
   begin
      if (!rstn)
         parity_flag <= PSF_STATUS_WORD_RST[PSF_PAR_BIT];
      else
         parity_flag <= ^accumulator;
   end

   // Status word image and banked register address, both registered
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         status_word   <= PSF_STATUS_WORD_RST;
         reg_file_addr <= PSF_BYTE_ZERO;
      end
      else
      begin
         status_word   <= {next_word[7:1], parity_flag};
         reg_file_addr <= {3'h0, register_bank_select, reg_index};
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence psf_div_zero_s;
      alu_req.valid && alu_req.op == PSF_OP_DIV &&
      alu_req.b == PSF_BYTE_ZERO;
   endsequence

   // Product or quotient taken by the datapath
   sequence psf_muldiv_s;
      alu_req.valid &&
      (alu_req.op == PSF_OP_MUL || alu_req.op == PSF_OP_DIV);
   endsequence

   aux_carry_add_a: assert property (
      alu_req.valid && alu_req.op == PSF_OP_ADD &&
      ({1'b0, alu_req.a[3:0]} + {1'b0, alu_req.b[3:0]}) > 5'(PSF_NIBBLE_MASK)
      |=> aux_carry_flag)
      else $error("aux carry not set on nibble carry");
   aux_carry_clr_a: assert property (
      alu_req.valid && alu_req.op == PSF_OP_ADD &&
      ({1'b0, alu_req.a[3:0]} + {1'b0, alu_req.b[3:0]}) <= 5'(PSF_NIBBLE_MASK)
      |=> !aux_carry_flag)
      else $error("aux carry not cleared");
   user_flag_hold_a: assert property (
      !sw_hit |=> $stable(user_flag_zero) && $stable(user_flag_one))
      else $error("user flag changed without write");
   bank_addr_a: assert property (
      1'b1 |=> reg_file_addr ==
      (({6'h00, $past(register_bank_select)} << PSF_BANK_SHIFT)
       | {5'h00, $past(reg_index)}))
      else $error("bank address wrong");
   ovf_add_a: assert property (
      alu_req.valid && alu_req.op == PSF_OP_ADD &&
      alu_req.a[7] == alu_req.b[7] &&
      (alu_req.a + alu_req.b) >= 8'h80 && !alu_req.a[7] |=> overflow_flag)
      else $error("signed overflow missed");
   ovf_mul_a: assert property (
      alu_req.valid && alu_req.op == PSF_OP_MUL &&
      (alu_req.a * alu_req.b) > 16'h00FF |=> overflow_flag)
      else $error("multiply overflow missed");
   ovf_div_a: assert property (
      psf_div_zero_s |=> overflow_flag ##1 status_word[PSF_OVF_BIT])
      else $error("divide by zero missed");
   ovf_clear_a: assert property (
      alu_req.valid && alu_req.op == PSF_OP_DIV &&
      alu_req.b != PSF_BYTE_ZERO |=> !overflow_flag)
      else $error("overflow not cleared");
   parity_track_a: assert property (
      1'b1 |=> ##1 status_word[PSF_PAR_BIT] == ^$past(accumulator, 2))
      else $error("parity wrong");
   carry_take_a: assert property (
      alu_req.valid && alu_req.op == PSF_OP_SUBB |=>
      carry_flag == $past(alu_req.carry_out))
      else $error("carry not updated");
   muldiv_clear_a: assert property (
      psf_muldiv_s |=> !carry_flag && !aux_carry_flag)
      else $error("carry flags not cleared by multiply or divide");
   sw_write_a: assert property (
      sw_hit && !sw_req.bit_wr |=>
      register_bank_select == $past(sw_req.wdata[PSF_BANK_HI:PSF_BANK_LO]))
      else $error("bank select write lost");

endmodule // psf_status_word

// >>> test/tb_top.sv
// Self-checking testbench for the program status word flag block
`timescale 1ns/10ps
module tb_top
   import psf_pkg::*;
;
   // ----------------------------------------------------------------
   // Clock, reset, stimulus and reference state
   // ----------------------------------------------------------------
   logic         clk = 1'b0;
   logic         rstn = 1'b0;
   psf_alu_req_t alu_req = '0;
   psf_sw_req_t  sw_req = '0;
   logic [7:0]   accumulator = 8'h00;
   logic [2:0]   reg_index = 3'h0;
   logic [7:0]   status_word;
   logic [7:0]   reg_file_addr;
   logic [1:0]   register_bank_select;
   logic [7:0]   m = 8'h00;     // Expected flags, bit 0 unused
   logic [31:0]  seed = 32'hA238;
   int           errors = 0;
   int           samples_checked = 0;
   psf_op_t      ops [7] = '{PSF_OP_NONE, PSF_OP_ADD, PSF_OP_ADDC,
                             PSF_OP_SUBB, PSF_OP_MUL, PSF_OP_DIV,
                             PSF_OP_CARRY_ONLY};
   // Corner cases: op, a, b
   logic [22:0]  cor [12] = '{{7'h02,8'h0F,8'h01}, {7'h02,8'h08,8'h08},
      {7'h02,8'h7F,8'h01}, {7'h02,8'hFF,8'h01}, {7'h02,8'h01,8'h01},
      {7'h08,8'h10,8'h01}, {7'h08,8'h80,8'h01}, {7'h10,8'h10,8'h10},
      {7'h10,8'hFF,8'h01}, {7'h20,8'h05,8'h00}, {7'h20,8'h05,8'h01},
      {7'h04,8'hFF,8'h00}};

   // 20 MHz clock
   always #25 clk = ~clk;

   psf_status_word i_dut (
      .clk                  (clk),
      .rstn                 (rstn),
      .alu_req              (alu_req),
      .sw_req               (sw_req),
      .accumulator          (accumulator),
      .reg_index            (reg_index),
      .status_word          (status_word),
      .reg_file_addr        (reg_file_addr),
      .register_bank_select (register_bank_select)
   );

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic chk(input string nm, input logic [7:0] e,
                      input logic [7:0] g, input logic [7:0] k);
      samples_checked++;
      if ((g & k) !== (e & k))
      begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e & k, g & k);
      end
   endtask

   task automatic conclude();
      if (errors == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // One request, reference update, then settled output checks
   task automatic step(input psf_op_t o, input logic v, input logic [7:0] a,
      input logic [7:0] b, input logic w, input logic bw,
      input logic [7:0] ad, input logic [2:0] bn, input logic [7:0] wd,
      input logic [7:0] acc, input logic [2:0] ri);
      logic [8:0]  s;
      logic [4:0]  h;
      logic [15:0] p;
      logic        ci;
      logic        co;
      logic [7:0]  e;
      ci = (o == PSF_OP_ADDC) ? m[7] : 1'b0;
      s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
      h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
      co = (o == PSF_OP_CARRY_ONLY) ? a[0] : a[1];
      if (o == PSF_OP_SUBB)
      begin
         s = {1'b0, a} - {1'b0, b} - {8'h00, m[7]};
         h = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, m[7]};
      end
      if (o == PSF_OP_ADD || o == PSF_OP_ADDC || o == PSF_OP_SUBB)
         co = s[8];
      p = {8'h00, a} * {8'h00, b};
      if (w && ad == PSF_STATUS_WORD_ADDR && bw && bn != 3'h0)
         m[bn] = wd[0];
      else if (w && ad == PSF_STATUS_WORD_ADDR && !bw)
         m = wd & 8'hFE;
      if (v)
         case (o)
            PSF_OP_ADD, PSF_OP_ADDC, PSF_OP_SUBB:
            begin
               m[7] = s[8];
               m[6] = h[4];
               m[2] = (o == PSF_OP_SUBB) ? (a[7] != b[7] && s[7] != a[7])
                                         : (a[7] == b[7] && s[7] != a[7]);
            end
            PSF_OP_MUL, PSF_OP_DIV:
            begin
               m[7:6] = 2'h0;
               m[2] = (o == PSF_OP_MUL) ? (p[15:8] != 8'h00) : (b == 8'h00);
            end
            PSF_OP_CARRY_ONLY: m[7] = co;
            default: ;
         endcase
      @(negedge clk);
      alu_req = '{valid: v, op: o, a: a, b: b, carry_out: co};
      sw_req = '{wr: w, bit_wr: bw, addr: ad, bit_num: bn, wdata: wd};
      accumulator = acc;
      reg_index = ri;
      @(negedge clk);
      alu_req.valid = 1'b0;
      sw_req.wr = 1'b0;
      repeat (3) @(negedge clk);
      e = {m[7:1], ^acc};
      chk("status_word", e, status_word, 8'hFF);
      chk("carry", e, status_word, 8'h80);
      chk("aux_carry", e, status_word, 8'h40);
      chk("overflow", e, status_word, 8'h04);
      chk("user_flags", e, status_word, 8'h22);
      chk("parity", e, status_word, 8'h01);
      chk("bank", {6'h00, m[4:3]}, {6'h00, register_bank_select},
          8'h03);
      chk("reg_file_addr", {3'h0, m[4:3], ri}, reg_file_addr,
          8'hFF);
   endtask

   task automatic reset_check();
      rstn = 1'b0;
      repeat (12) @(negedge clk);
      chk("reset_word", 8'h00, status_word, 8'hFF);
      chk("reset_addr", 8'h00, reg_file_addr, 8'hFF);
      rstn = 1'b1;
      m = 8'h00;
   endtask

   // ----------------------------------------------------------------
   // Main sequence: reset, corners, banks, random, mid-run reset
   // ----------------------------------------------------------------
   initial
   begin
      logic [31:0] r;
      logic [31:0] q;
      logic [31:0] t;
      psf_op_t     o;
      reset_check();
      foreach (cor[k])
         step(psf_op_t'(cor[k][22:16]), 1'b1, cor[k][15:8], cor[k][7:0],
              1'b0, 1'b0, 8'h00, 3'h0, 8'h00, cor[k][15:8], 3'h2);
      for (int bk = 0; bk < 4; bk++)
         step(PSF_OP_NONE, 1'b0, 8'h00, 8'h00, 1'b1, 1'b0,
              PSF_STATUS_WORD_ADDR, 3'h0, {3'h0, bk[1:0], 3'h7},
              8'h01, 3'h7);
      // Simultaneous write and add: hardware owns the arithmetic flags
      step(PSF_OP_ADD, 1'b1, 8'h7F, 8'h01, 1'b1, 1'b0, PSF_STATUS_WORD_ADDR,
           3'h0, 8'h3B, 8'h03, 3'h5);
      for (int i = 0; i < 300; i++)
      begin
         r = xs();
         q = xs();
         t = xs();
         o = (r[2:0] == 3'h7) ? PSF_OP_NONE : ops[r[2:0]];
         step(o, r[3] | r[4], q[7:0], q[15:8],
              r[5] & (~(r[3] | r[4]) | (o == PSF_OP_ADD)), r[6],
              r[7] ? PSF_STATUS_WORD_ADDR : r[15:8], r[18:16], r[26:19],
              t[7:0], t[10:8]);
         if (i == 150)
            reset_check();
      end
      conclude();
   end

   // Watchdog, well beyond the expected run of about 1,600 cycles
   initial
   begin
      #800000;
      errors++;
      conclude();
   end
endmodule // tb_top
